// File: design/tic_pkg.sv
package tic_pkg;
    // ----------------------------------------------------------------
    // register addresses on the core's special-function bus
    // ----------------------------------------------------------------
    localparam logic [7:0] TICK_CONTROL_ADDR = 8'hA1;
    localparam logic [7:0] FRACTION_TICK_COUNT_ADDR = 8'hA2;
    localparam logic [7:0] ONE_HZ_COUNT_ADDR = 8'hA3;
    localparam logic [7:0] MINUTE_COUNT_ADDR = 8'hA4;
    localparam logic [7:0] HOUR_COUNT_ADDR = 8'hA5;
    localparam logic [7:0] INTERVAL_COMPARE_VALUE_ADDR = 8'hA6;

    // ----------------------------------------------------------------
    // tick_control field positions
    // ----------------------------------------------------------------
    localparam int CTL_GATE_BIT = 0;
    localparam int CTL_RUN_BIT = 1;
    localparam int CTL_FLAG_BIT = 2;
    localparam int CTL_ONE_SHOT_BIT = 3;
    localparam int CTL_SEL_LO_BIT = 4;
    localparam int CTL_SEL_HI_BIT = 5;
    localparam int CTL_DAY_WRAP_BIT = 6;
    localparam int CTL_WIDTH = 7;

    // ----------------------------------------------------------------
    // reset values and count limits
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [CTL_WIDTH-1:0] CTL_RESET = 7'h00;
    localparam logic [7:0] FRACTION_MAX = 8'h7F;
    localparam logic [7:0] SIXTY_MAX = 8'h3B;
    localparam logic [7:0] DAY_HOUR_MAX = 8'h17;
    localparam logic [7:0] FULL_HOUR_MAX = 8'hFF;

    // ----------------------------------------------------------------
    // timebase: 1/128 second at a 10 ns core clock
    // ----------------------------------------------------------------
    localparam longint TICK_PERIOD_NS = 7812500;
    localparam longint CORE_CLK_PERIOD_NS = 10;
    localparam int TICK_CYCLES = int'(TICK_PERIOD_NS / CORE_CLK_PERIOD_NS);
    localparam int PRESCALE_WIDTH = 24;

    typedef enum logic [1:0] {
        BASE_FRACTION = 2'b00,
        BASE_SECOND = 2'b01,
        BASE_MINUTE = 2'b10,
        BASE_HOUR = 2'b11
    } timebase_t;

    typedef struct packed {
        logic [7:0] frac;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] cmp;
        logic [7:0] icnt;
        logic [CTL_WIDTH-1:0] ctl;
        logic irq;
        logic [7:0] rdata;
    } tic_state_t;
endpackage : tic_pkg

// File: design/tic_tick_if.sv
`timescale 1ns/1ps
interface tic_tick_if;
    logic gate_on;
    logic tick;
    modport source (input gate_on, output tick);
    modport sink (output gate_on, input tick);
endinterface : tic_tick_if

// File: design/tic_prescaler.sv
`timescale 1ns/1ps
module tic_prescaler
    import tic_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    tic_tick_if.source tb
);
    typedef struct packed {
        logic [PRESCALE_WIDTH-1:0] cnt;
    } pre_state_t;

    pre_state_t s;
    pre_state_t next_s;
    localparam logic [PRESCALE_WIDTH-1:0] LAST = PRESCALE_WIDTH'(TICK_CYCLES_P - 1);

    // gate low holds the divider at zero so a restart gives a full first period
    always_comb begin
        next_s = s;
        if (!tb.gate_on) begin
            next_s.cnt = '0;
        end else if (s.cnt == LAST) begin
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + PRESCALE_WIDTH'(1);
        end
    end

    assign tb.tick = tb.gate_on && (s.cnt == LAST);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_tick_gated;
        tb.tick |-> tb.gate_on && $past(tb.gate_on);
    endproperty
    a_tick_gated: assert property (p_tick_gated) else $error("tick while gate low");
endmodule : tic_prescaler

// File: design/time_interval_counter.sv
`timescale 1ns/1ps
module time_interval_counter
    import tic_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic secondary_irq_control,
    output logic [7:0] sfr_rdata,
    output logic tic_irq
);
    tic_state_t s;
    tic_state_t next_s;
    tic_tick_if tb ();

    logic frac_wrap;
    logic sec_wrap;
    logic min_wrap;
    logic unit_tick;
    logic match;
    logic [7:0] icnt_inc;
    logic [7:0] hour_max;

    function automatic logic [7:0] wrap_inc(input logic [7:0] v, input logic [7:0] max);
        wrap_inc = (v >= max) ? 8'h00 : v + 8'h01;
    endfunction : wrap_inc

    function automatic logic hits(input logic [7:0] a);
        hits = sfr_wr && (sfr_addr == a);
    endfunction : hits

    tic_prescaler #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_prescaler (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tb(tb)
    );

    assign tb.gate_on = s.ctl[CTL_GATE_BIT];

    // ----------------------------------------------------------------
    // time-of-day cascade
    // ----------------------------------------------------------------
    // fraction wrap
    assign frac_wrap = tb.tick && (s.frac >= FRACTION_MAX);
    assign sec_wrap = frac_wrap && (s.sec >= SIXTY_MAX);
    assign min_wrap = sec_wrap && (s.min >= SIXTY_MAX);
    assign hour_max = s.ctl[CTL_DAY_WRAP_BIT] ? DAY_HOUR_MAX : FULL_HOUR_MAX;

    always_comb begin
        case (timebase_t'(s.ctl[CTL_SEL_HI_BIT:CTL_SEL_LO_BIT]))
            BASE_FRACTION: unit_tick = tb.tick;
            BASE_SECOND: unit_tick = frac_wrap;
            BASE_MINUTE: unit_tick = sec_wrap;
            BASE_HOUR: unit_tick = min_wrap;
            default: unit_tick = 1'b0;
        endcase
    end

    assign icnt_inc = s.icnt + 8'h01;
    assign match = s.ctl[CTL_RUN_BIT] && unit_tick && (icnt_inc == s.cmp);

    always_comb begin
        next_s = s;
        if (tb.tick) begin
            next_s.frac = wrap_inc(s.frac, FRACTION_MAX);
        end
        if (frac_wrap) begin
            next_s.sec = wrap_inc(s.sec, SIXTY_MAX);
        end
        if (sec_wrap) begin
            next_s.min = wrap_inc(s.min, SIXTY_MAX);
        end
        if (min_wrap) begin
            next_s.hour = wrap_inc(s.hour, hour_max);
        end
        if (s.ctl[CTL_RUN_BIT] && unit_tick) begin
            next_s.icnt = icnt_inc;
        end

        // ------------------------------------------------------------
        // software writes
        // ------------------------------------------------------------
        if (hits(TICK_CONTROL_ADDR)) begin
            next_s.ctl = sfr_wdata[CTL_WIDTH-1:0];
            if (s.ctl[CTL_GATE_BIT] && !sfr_wdata[CTL_GATE_BIT]) begin
                next_s.frac = REG_RESET;
                next_s.sec = REG_RESET;
                next_s.min = REG_RESET;
                next_s.hour = REG_RESET;
            end
        end
        if (!s.ctl[CTL_GATE_BIT]) begin
            if (hits(FRACTION_TICK_COUNT_ADDR)) begin
                next_s.frac = sfr_wdata;
            end
            if (hits(ONE_HZ_COUNT_ADDR)) begin
                next_s.sec = sfr_wdata;
            end
            if (hits(MINUTE_COUNT_ADDR)) begin
                next_s.min = sfr_wdata;
            end
            if (hits(HOUR_COUNT_ADDR)) begin
                next_s.hour = sfr_wdata;
            end
        end
        if (hits(INTERVAL_COMPARE_VALUE_ADDR)) begin
            next_s.cmp = sfr_wdata;
        end

        // a match in the same cycle as a software clear of the flag wins
        if (match) begin
            next_s.ctl[CTL_FLAG_BIT] = 1'b1;
            next_s.icnt = 8'h00;
            if (s.ctl[CTL_ONE_SHOT_BIT]) begin
                next_s.ctl[CTL_RUN_BIT] = 1'b0;
            end
        end
        if (!next_s.ctl[CTL_RUN_BIT]) begin
            next_s.icnt = 8'h00;
        end
        next_s.irq = next_s.ctl[CTL_FLAG_BIT] && secondary_irq_control;

        // read data lags the address by one cycle; unmapped reads return zero
        case (sfr_addr)
            TICK_CONTROL_ADDR: next_s.rdata = {1'b0, s.ctl};
            FRACTION_TICK_COUNT_ADDR: next_s.rdata = s.frac;
            ONE_HZ_COUNT_ADDR: next_s.rdata = s.sec;
            MINUTE_COUNT_ADDR: next_s.rdata = s.min;
            HOUR_COUNT_ADDR: next_s.rdata = s.hour;
            INTERVAL_COMPARE_VALUE_ADDR: next_s.rdata = s.cmp;
            default: next_s.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s <= '{frac: REG_RESET, sec: REG_RESET, min: REG_RESET, hour: REG_RESET,
                   cmp: REG_RESET, icnt: REG_RESET, ctl: CTL_RESET, irq: 1'b0, rdata: REG_RESET};
        end else begin
            s <= next_s;
        end
    end

    assign sfr_rdata = s.rdata;
    assign tic_irq = s.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_match_sets;
        s.ctl[CTL_RUN_BIT] && unit_tick && (icnt_inc == s.cmp) |=> s.ctl[CTL_FLAG_BIT] && (s.icnt == 8'h00);
    endproperty
    a_match_sets: assert property (p_match_sets) else $error("match did not set flag");

    property p_flag_sticky;
        s.ctl[CTL_FLAG_BIT] && !(hits(TICK_CONTROL_ADDR) && !sfr_wdata[CTL_FLAG_BIT]) |=> s.ctl[CTL_FLAG_BIT];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear");

    property p_run_off_zero;
        !s.ctl[CTL_RUN_BIT] |-> s.icnt == 8'h00;
    endproperty
    a_run_off_zero: assert property (p_run_off_zero) else $error("stopped counter not zero");

    property p_gate_clear;
        s.ctl[CTL_GATE_BIT] && hits(TICK_CONTROL_ADDR) && !sfr_wdata[CTL_GATE_BIT]
            |=> s.frac == 8'h00 && s.sec == 8'h00 && s.min == 8'h00 && s.hour == 8'h00;
    endproperty
    a_gate_clear: assert property (p_gate_clear) else $error("time not cleared on gate off");

    property p_preset;
        !s.ctl[CTL_GATE_BIT] && hits(ONE_HZ_COUNT_ADDR) |=> s.sec == $past(sfr_wdata);
    endproperty
    a_preset: assert property (p_preset) else $error("seconds preset lost");

    property p_irq;
        tic_irq |-> s.ctl[CTL_FLAG_BIT] && $past(secondary_irq_control);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without enabled flag");

    property p_cmp_write;
        hits(INTERVAL_COMPARE_VALUE_ADDR) |=> s.cmp == $past(sfr_wdata);
    endproperty
    a_cmp_write: assert property (p_cmp_write) else $error("compare write lost");

    property p_frac_wrap;
        frac_wrap && !sfr_wr |=> s.frac == 8'h00 && s.sec != $past(s.sec);
    endproperty
    a_frac_wrap: assert property (p_frac_wrap) else $error("fraction wrap wrong");

    property p_oneshot;
        match && s.ctl[CTL_ONE_SHOT_BIT] |=> !s.ctl[CTL_RUN_BIT];
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot kept running");

    property p_day_wrap;
        min_wrap && s.ctl[CTL_DAY_WRAP_BIT] && s.hour == DAY_HOUR_MAX && !sfr_wr |=> s.hour == 8'h00;
    endproperty
    a_day_wrap: assert property (p_day_wrap) else $error("hour did not wrap at 23");

    c_match: cover property (match);
    c_oneshot: cover property (match && s.ctl[CTL_ONE_SHOT_BIT]);
    c_irq: cover property (!tic_irq ##1 tic_irq);
    c_hour_wrap: cover property (min_wrap && s.hour == hour_max);
endmodule : time_interval_counter

// File: verification/tb_time_interval_counter.sv
`timescale 1ns/1ps
module tb_time_interval_counter;
    import tic_pkg::*;
    // short timebase so a whole fraction tick is four core cycles
    localparam int TC = 4;
    localparam int CYCLE_LIMIT = 20000;
    logic core_clk;
    logic rst_n;
    logic sfr_wr;
    logic secondary_irq_control;
    logic tic_irq;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic [7:0] v;
    logic [7:0] f;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    int t0;
    // preset sec, min, hour, day wrap, then expected sec, min, hour after one fraction wrap
    logic [7:0] tsec[6] = '{8'h3B, 8'h3B, 8'h3B, 8'h3B, 8'h3A, 8'h3B};
    logic [7:0] tmin[6] = '{8'h3B, 8'h3B, 8'h3B, 8'h3B, 8'h3B, 8'h0A};
    logic [7:0] thr[6] = '{8'h16, 8'h17, 8'h17, 8'hFF, 8'h05, 8'h05};
    logic [7:0] tdw[6] = '{8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] esec[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3B, 8'h00};
    logic [7:0] emin[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3B, 8'h0B};
    logic [7:0] ehr[6] = '{8'h17, 8'h00, 8'h18, 8'h00, 8'h05, 8'h05};

    time_interval_counter #(.TICK_CYCLES_P(TC)) uut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .secondary_irq_control(secondary_irq_control),
        .sfr_rdata(sfr_rdata),
        .tic_irq(tic_irq)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == CYCLE_LIMIT) begin
            n_mismatch = n_mismatch + 1;
            test_done();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge core_clk);
        #1;
        sfr_wr = 1'b0;
    endtask : wr

    // read data belongs to the address sampled one edge earlier
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        sfr_addr = a;
        @(posedge core_clk);
        #1;
        d = sfr_rdata;
    endtask : rd

    // stop the gate first so the presets are accepted
    task automatic start(input logic [7:0] fr, s, m, h, c, ctl);
        wr(8'hA1, 8'h00);
        wr(8'hA2, fr);
        wr(8'hA3, s);
        wr(8'hA4, m);
        wr(8'hA5, h);
        wr(8'hA6, c);
        wr(8'hA1, ctl);
    endtask : start

    task automatic wait_irq(input int lim);
        n = 0;
        while (tic_irq !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask : wait_irq

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        secondary_irq_control = 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        for (int a = 'hA0; a < 'hA8; a++) begin
            rd(a[7:0], v);
            chk(v, 8'h00);
        end
        wr(8'hA7, 8'h5A);
        rd(8'hA7, v);
        chk(v, 8'h00);
        wr(8'hA6, 8'hFF);
        rd(8'hA6, v);
        chk(v, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            start(8'h7F, tsec[i], tmin[i], thr[i], 8'h00, 8'h01 | tdw[i]);
            v = 8'h7F;
            for (int k = 0; k < 20 && v === 8'h7F; k++) rd(8'hA2, v);
            chk({7'h00, v < 8'h02}, 8'h01);
            rd(8'hA3, v);
            chk(v, esec[i]);
            rd(8'hA4, v);
            chk(v, emin[i]);
            rd(8'hA5, v);
            chk(v, ehr[i]);
            wr(8'hA3, 8'h11);
            rd(8'hA3, v);
            chk(v, esec[i]);
        end
        wr(8'hA1, 8'h00);
        repeat (20) @(posedge core_clk);
        for (int a = 'hA2; a < 'hA6; a++) begin
            rd(a[7:0], v);
            chk(v, 8'h00);
        end
        // a preset chain makes the selected unit tick soon; with the fraction at zero the slower units do not
        for (int s = 0; s < 4; s++) begin
            for (int ng = 0; ng < 2; ng++) begin
                if (s == 0 && ng == 1) continue;
                f = (ng == 1) ? 8'h00 : 8'h7F;
                start(f, (s >= 2) ? 8'h3B : 8'h00, (s == 3) ? 8'h3B : 8'h00, 8'h00, 8'h01, {2'b00, s[1:0], 4'h3});
                wait_irq(40);
                chk({7'h00, n < 40}, {7'h00, ng == 0});
            end
        end
        start(8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03);
        wait_irq(40);
        t0 = cyc;
        wr(8'hA1, 8'h03);
        repeat (2) @(posedge core_clk);
        #1;
        wait_irq(40);
        chk(8'(cyc - t0), 8'h0C);
        repeat (30) @(posedge core_clk);
        rd(8'hA1, v);
        chk(v, 8'h07);
        secondary_irq_control = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk({7'h00, tic_irq}, 8'h00);
        secondary_irq_control = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk({7'h00, tic_irq}, 8'h01);
        start(8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h03);
        repeat (8) @(posedge core_clk);
        wr(8'hA1, 8'h01);
        wr(8'hA1, 8'h03);
        wait_irq(40);
        chk({7'h00, n >= 16 && n < 40}, 8'h01);
        start(8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h0B);
        wait_irq(40);
        chk({7'h00, n < 40}, 8'h01);
        rd(8'hA1, v);
        chk(v, 8'h0D);
        wr(8'hA1, 8'h09);
        repeat (40) @(posedge core_clk);
        #1;
        chk({7'h00, tic_irq}, 8'h00);
        // software may raise the flag itself; it then sticks and requests
        wr(8'hA1, 8'h04);
        rd(8'hA1, v);
        chk(v, 8'h04);
        chk({7'h00, tic_irq}, 8'h01);
        test_done();
    end
endmodule : tb_time_interval_counter
